// ### hdl/adcal_unit.v
// Purpose: calibration control and correction registers
// Assumes: filter results and commands on REF_CLK, CS_N a pin
// Notes: full-scale gain found by a serial divider
`timescale 1ns/1ps
`include "adcal_regs.vh"

module adcal_unit (
  // clock and reset
  input wire REF_CLK,
  input wire RSTN,
  // register port
  input wire REG_WR,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  // command port
  input wire CMD_VALID,
  input wire [1:0] CMD_CODE,
  input wire REG_LOCKED,
  input wire CS_N,
  // filter side
  input wire FILT_VALID,
  input wire [23:0] FILT_DATA,
  // conversion control
  output reg CONV_START,
  output reg INPUT_DISCONNECT,
  output reg CAL_BUSY,
  // corrected data
  output wire DATA_VALID,
  output wire [23:0] DATA_OUT,
  output wire OVERRANGE,
  output reg DATA_READY_N
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'h0; // normal conversions
  localparam ST_AVG = 3'h1; // collecting 16 results
  localparam ST_DIV = 3'h2; // gain division
  localparam ST_CONV = 3'h3; // final conversion
  localparam ST_RST = 3'h4; // restart delay

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [2:0] state_reg; // control state
  reg [1:0] kind_reg; // calibration in progress
  reg [23:0] ofs_reg; // offset_correction_word
  reg [23:0] gain_reg; // gain_correction_word
  reg [27:0] sum_reg; // signed sum of results
  reg [4:0] cnt_reg; // results collected
  reg [9:0] dly_reg; // restart delay count
  reg [44:0] num_reg; // divider numerator shifter
  reg [24:0] rem_reg; // divider remainder
  reg [44:0] quo_reg; // divider quotient
  reg [24:0] den_reg; // divider denominator
  reg [5:0] step_reg; // divider steps left
  reg cs_meta_reg; // chip select first stage
  reg cs_sync_reg; // chip select synchronised
  reg cs_prev_reg; // for rising edge
  wire cs_rise; // chip select went high
  wire [23:0] avg; // mean of 16 results
  wire [24:0] rem_try; // shifted remainder
  wire cal_cmd; // accepted calibration command
  wire corr_in_valid; // result to correct
  wire corr_valid; // corrected result ready
  wire [27:0] ofs_sum; // sum including the 16th result

  // ----------------------------------------
  // chip select synchroniser
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= CS_N;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end

  assign cs_rise = cs_sync_reg & ~cs_prev_reg;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  assign avg = sum_reg[27:4]; // divide by 16
  assign rem_try = {rem_reg[23:0], num_reg[44]};
  assign ofs_sum = sum_reg + {{4{FILT_DATA[23]}}, FILT_DATA};
  assign cal_cmd = CMD_VALID && !REG_LOCKED && (CMD_CODE != `ADCAL_CMD_RESET); // RL18
  // results reach the output only in idle and in the final conversion
  assign corr_in_valid = FILT_VALID && ((state_reg == ST_IDLE) || (state_reg == ST_CONV));

  // ----------------------------------------
  // correction datapath
  // ----------------------------------------
  adcal_corr u_corr (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .in_valid(corr_in_valid),
    .in_data(FILT_DATA),
    .ofs_word(ofs_reg),
    .gain_word(gain_reg),
    .out_valid(corr_valid),
    .out_data(DATA_OUT),
    .out_ovr(OVERRANGE)
  );

  assign DATA_VALID = corr_valid;

  // ----------------------------------------
  // control state machine
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
      kind_reg <= `ADCAL_CMD_RESET;
      ofs_reg <= `ADCAL_OFS_RESET;
      gain_reg <= `ADCAL_GAIN_RESET;
      sum_reg <= 28'h0000000;
      cnt_reg <= 5'h00;
      dly_reg <= 10'h000;
      num_reg <= 45'h000000000000;
      rem_reg <= 25'h0000000;
      quo_reg <= 45'h000000000000;
      den_reg <= 25'h0000001;
      step_reg <= 6'h00;
      CONV_START <= 1'b0;
      INPUT_DISCONNECT <= 1'b0;
      CAL_BUSY <= 1'b0;
    end else begin
      CONV_START <= 1'b0;
      // host writes reach the words directly
      if (REG_WR) begin
        case (REG_ADDR)
          `ADCAL_OFS_LOW: ofs_reg[7:0] <= REG_WDATA; // RL5 RL17
          `ADCAL_OFS_MID: ofs_reg[15:8] <= REG_WDATA; // RL5 RL17
          `ADCAL_OFS_HIGH: ofs_reg[23:16] <= REG_WDATA; // RL5 RL17
          `ADCAL_GAIN_LOW: gain_reg[7:0] <= REG_WDATA; // RL7 RL17
          `ADCAL_GAIN_MID: gain_reg[15:8] <= REG_WDATA; // RL7 RL17
          `ADCAL_GAIN_HIGH: gain_reg[23:16] <= REG_WDATA; // RL7 RL17
          default: ;
        endcase
      end
      if (CMD_VALID && (CMD_CODE == `ADCAL_CMD_RESET)) begin
        // reset command: registers back to defaults, restart delay
        state_reg <= ST_RST;
        ofs_reg <= `ADCAL_OFS_RESET;
        gain_reg <= `ADCAL_GAIN_RESET;
        dly_reg <= 10'h000;
        // clear the divider so the next full-scale cal reloads it
        num_reg <= 45'h000000000000;
        quo_reg <= 45'h000000000000;
        step_reg <= 6'h00;
        INPUT_DISCONNECT <= 1'b0;
        CAL_BUSY <= 1'b0;
      end else if ((state_reg != ST_IDLE) && (state_reg != ST_RST) && cs_rise) begin
        // chip select high cancels the calibration
        state_reg <= ST_IDLE; // RL19
        INPUT_DISCONNECT <= 1'b0; // RL19
        CAL_BUSY <= 1'b0; // RL19
        // a cut division must not leave its load marker behind
        num_reg <= 45'h000000000000;
        quo_reg <= 45'h000000000000;
        step_reg <= 6'h00;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (cal_cmd) begin
              state_reg <= ST_AVG;
              kind_reg <= CMD_CODE;
              sum_reg <= 28'h0000000;
              cnt_reg <= 5'h00;
              CAL_BUSY <= 1'b1;
              CONV_START <= 1'b1;
              // only the self offset cal shorts the amplifier
              INPUT_DISCONNECT <= (CMD_CODE == `ADCAL_CMD_SELF_OFS); // RL10 RL12
            end
          end
          ST_AVG: begin
            if (FILT_VALID) begin
              sum_reg <= sum_reg + {{4{FILT_DATA[23]}}, FILT_DATA}; // RL10 RL12 RL13
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == (`ADCAL_AVG_COUNT - 5'h01)) begin
                if (kind_reg == `ADCAL_CMD_FULL_SCALE) begin
                  state_reg <= ST_DIV; // RL13
                end else begin
                  state_reg <= ST_CONV;
                  INPUT_DISCONNECT <= 1'b0; // RL11
                  CONV_START <= 1'b1; // RL11 RL12
                end
              end
            end
          end
          ST_DIV: begin
            if (step_reg == 6'h00 && num_reg == 45'h000000000000 && quo_reg == 45'h000000000000) begin
              // load: full scale times unity over corrected average
              num_reg <= {`ADCAL_POS_FULL, 21'h000000} << 1; // RL13
              rem_reg <= 25'h0000000;
              den_reg <= $signed({avg[23], avg}) - $signed({ofs_reg[23], ofs_reg}); // RL13 RL21
              step_reg <= `ADCAL_DIV_STEPS;
              quo_reg <= 45'h000000000001;
            end else if (step_reg != 6'h00) begin
              // one restoring step per clock
              num_reg <= {num_reg[43:0], 1'b0};
              if (rem_try >= den_reg) begin
                rem_reg <= rem_try - den_reg;
                quo_reg <= {quo_reg[43:0], 1'b1};
              end else begin
                rem_reg <= rem_try;
                quo_reg <= {quo_reg[43:0], 1'b0};
              end
              step_reg <= step_reg - 6'h01;
            end else begin
              // non-positive average or oversize result clips
              if (den_reg[24] || den_reg == 25'h0000000 || quo_reg[44:24] != 21'h000000) begin
                gain_reg <= 24'hFFFFFF; // RL13
              end else begin
                gain_reg <= quo_reg[23:0]; // RL13 RL20
              end
              num_reg <= 45'h000000000000;
              quo_reg <= 45'h000000000000;
              state_reg <= ST_CONV;
              CONV_START <= 1'b1; // RL14
            end
          end
          ST_CONV: begin
            if (FILT_VALID) begin
              // new words already in use for this result
              state_reg <= ST_IDLE; // RL11 RL14
              CAL_BUSY <= 1'b0;
            end
          end
          ST_RST: begin
            dly_reg <= dly_reg + 10'h001;
            if (dly_reg == (`ADCAL_RESTART_CYCLES - 10'h001)) begin
              CONV_START <= 1'b1; // RL1
              state_reg <= ST_IDLE;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
        // offset cals store the average once 16 are summed
        if (state_reg == ST_AVG && FILT_VALID && kind_reg != `ADCAL_CMD_FULL_SCALE &&
            cnt_reg == (`ADCAL_AVG_COUNT - 5'h01)) begin
          ofs_reg <= ofs_sum[27:4]; // RL10 RL12 RL20
        end
      end
    end
  end

  // ----------------------------------------
  // data ready and read back
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DATA_READY_N <= 1'b1;
      REG_RDATA <= 8'h00;
    end else begin
      if (corr_valid) begin
        DATA_READY_N <= 1'b0; // RL20
      end else if (CONV_START || (FILT_VALID && !corr_in_valid)) begin
        DATA_READY_N <= 1'b1;
      end
      case (REG_ADDR)
        `ADCAL_OFS_LOW: REG_RDATA <= ofs_reg[7:0];
        `ADCAL_OFS_MID: REG_RDATA <= ofs_reg[15:8];
        `ADCAL_OFS_HIGH: REG_RDATA <= ofs_reg[23:16];
        `ADCAL_GAIN_LOW: REG_RDATA <= gain_reg[7:0];
        `ADCAL_GAIN_MID: REG_RDATA <= gain_reg[15:8];
        `ADCAL_GAIN_HIGH: REG_RDATA <= gain_reg[23:16];
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

endmodule // adcal_unit

// ### hdl/adcal_regs.vh
// Purpose: constants of the adc calibration unit
// Assumes: 10 MHz REF_CLK, byte-wide register port
// Notes: offsets are byte register addresses
// Function
// RL1: conversion restarts 512 clocks after reset command
// RL2: host raises chip select before reset command
// RL3: output is (data - offset) * gain / 400000h
// RL4: corrected result saturates to 24 bits
// RL5: offset word at bytes 07h, 08h, 09h
// RL6: offset word is two's complement, zero neutral
// RL7: gain word at bytes 0Ah, 0Bh, 0Ch
// RL8: gain word unsigned, unity at 400000h
// RL9: beyond 106 percent flags overrange
// RL10: self offset cal shorts inputs, averages 16
// RL11: self offset cal ends with one conversion
// RL12: system offset cal averages 16, then converts
// RL13: full-scale cal averages 16, computes gain
// RL14: full-scale cal ends with one conversion
// RL15: host runs offset cal before full-scale
// RL16: host applies settled full-scale voltage first
// RL17: host writes to correction registers take effect
// RL18: calibration commands only while registers unlocked
// RL19: chip select rising abandons calibration
// RL20: calibration end updates words, data ready low
// RL21: wide intermediates, no overflow before saturation
`ifndef ADCAL_REGS_VH
`define ADCAL_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADCAL_OFS_LOW 8'h07
`define ADCAL_OFS_MID 8'h08
`define ADCAL_OFS_HIGH 8'h09
`define ADCAL_GAIN_LOW 8'h0A
`define ADCAL_GAIN_MID 8'h0B
`define ADCAL_GAIN_HIGH 8'h0C

// ----------------------------------------
// reset values and scaling
// ----------------------------------------
`define ADCAL_OFS_RESET 24'h000000
`define ADCAL_GAIN_RESET 24'h400000
`define ADCAL_GAIN_SHIFT 22
`define ADCAL_POS_FULL 24'h7FFFFF
`define ADCAL_NEG_FULL 24'h800000
`define ADCAL_OVR_LIMIT 27'h087AEDC
`define ADCAL_AVG_COUNT 5'h10
`define ADCAL_AVG_SHIFT 4

// ----------------------------------------
// commands
// ----------------------------------------
`define ADCAL_CMD_RESET 2'h0
`define ADCAL_CMD_SELF_OFS 2'h1
`define ADCAL_CMD_SYS_OFS 2'h2
`define ADCAL_CMD_FULL_SCALE 2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define ADCAL_RESTART_CYCLES 10'h200
`define ADCAL_DIV_STEPS 6'h2D

`endif

// ### hdl/adcal_corr.v
// Purpose: offset and gain correction with saturation
// Assumes: one filter result at a time, same clock
// Notes: one cycle latency, outputs registered
`timescale 1ns/1ps
`include "adcal_regs.vh"

module adcal_corr (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // raw result
  input wire in_valid,
  input wire [23:0] in_data,
  // correction words
  input wire [23:0] ofs_word,
  input wire [23:0] gain_word,
  // corrected result
  output reg out_valid,
  output reg [23:0] out_data,
  output reg out_ovr
);

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  wire signed [24:0] diff; // 25 bits hold any difference
  wire signed [49:0] prod; // signed times unsigned gain
  wire signed [27:0] scaled; // after division by 400000h
  reg [23:0] sat_data; // clipped value

  assign diff = $signed({in_data[23], in_data}) - $signed({ofs_word[23], ofs_word}); // RL3 RL6 RL21
  assign prod = diff * $signed({1'b0, gain_word}); // RL3 RL8 RL21
  assign scaled = prod[49:22]; // RL3

  // clip to 24 bits
  always @* begin
    if (scaled > $signed({4'h0, `ADCAL_POS_FULL})) begin
      sat_data = `ADCAL_POS_FULL; // RL4
    end else if (scaled < $signed({4'hF, `ADCAL_NEG_FULL})) begin
      sat_data = `ADCAL_NEG_FULL; // RL4
    end else begin
      sat_data = scaled[23:0];
    end
  end

  // register result and overrange
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= 24'h000000;
      out_ovr <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_data <= sat_data;
        out_ovr <= (scaled > $signed({1'b0, `ADCAL_OVR_LIMIT})) ||
                   (scaled < -$signed({1'b0, `ADCAL_OVR_LIMIT})); // RL9
      end
    end
  end

endmodule // adcal_corr

// ### bench/adcal_chk.sv
// Purpose: port checker of adcal_unit
// Assumes: one clock, RSTN low resets
// Notes: bound to every adcal_unit
`timescale 1ns/1ps
module adcal_chk (
  // clock and reset
  input wire REF_CLK,
  input wire RSTN,
  // requests
  input wire CMD_VALID,
  input wire [1:0] CMD_CODE,
  input wire REG_LOCKED,
  input wire CS_N,
  input wire FILT_VALID,
  // answers
  input wire CONV_START,
  input wire INPUT_DISCONNECT,
  input wire CAL_BUSY,
  input wire DATA_VALID,
  input wire [23:0] DATA_OUT,
  input wire OVERRANGE,
  input wire DATA_READY_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  reg [9:0] wait_reg; // edges since reset command
  wire cal_ok = CMD_VALID && CMD_CODE != 2'h0 && !REG_LOCKED && !CAL_BUSY && !CS_N && wait_reg == 10'h000;
  // count edges of the restart wait
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) wait_reg <= 10'h000;
    else if (CMD_VALID && CMD_CODE == 2'h0) wait_reg <= 10'h001;
    else if (wait_reg == 10'h201 || wait_reg == 10'h000) wait_reg <= 10'h000;
    else wait_reg <= wait_reg + 10'h001;
  end
  sequence s_self; cal_ok && CMD_CODE == 2'h1; endsequence
  sequence s_go; CONV_START && CAL_BUSY; endsequence
  property p_restart; wait_reg != 10'h000 |-> (CONV_START == (wait_reg == 10'h201)); endproperty
  a_restart: assert property (p_restart) else $error("restart delay wrong");
  property p_cal_go; cal_ok |=> s_go; endproperty
  a_cal_go: assert property (p_cal_go) else $error("calibration not started");
  property p_locked; CMD_VALID && CMD_CODE != 2'h0 && REG_LOCKED && !CAL_BUSY |=> !CAL_BUSY; endproperty
  a_locked: assert property (p_locked) else $error("locked command taken");
  property p_short; s_self |=> INPUT_DISCONNECT; endproperty
  a_short: assert property (p_short) else $error("inputs not shorted");
  property p_open; cal_ok && CMD_CODE != 2'h1 |=> !INPUT_DISCONNECT; endproperty
  a_open: assert property (p_open) else $error("inputs shorted");
  property p_reconn; $fell(INPUT_DISCONNECT) && !CS_N |-> CONV_START; endproperty
  a_reconn: assert property (p_reconn) else $error("no conversion after reconnect");
  property p_ready; DATA_VALID |=> !DATA_READY_N; endproperty
  a_ready: assert property (p_ready) else $error("data ready not low");
  property p_lat; DATA_VALID |-> $past(FILT_VALID); endproperty
  a_lat: assert property (p_lat) else $error("result without filter data");
  property p_clip; DATA_VALID && DATA_OUT != 24'h7FFFFF && DATA_OUT != 24'h800000 |-> !OVERRANGE; endproperty
  a_clip: assert property (p_clip) else $error("overrange without clipping");
  property p_abort; $rose(CS_N) && CAL_BUSY |-> ##[1:5] !CAL_BUSY; endproperty
  a_abort: assert property (p_abort) else $error("calibration not abandoned");
endmodule // adcal_chk
bind adcal_unit adcal_chk chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
  .REG_LOCKED(REG_LOCKED), .CS_N(CS_N), .FILT_VALID(FILT_VALID), .CONV_START(CONV_START),
  .INPUT_DISCONNECT(INPUT_DISCONNECT), .CAL_BUSY(CAL_BUSY), .DATA_VALID(DATA_VALID), .DATA_OUT(DATA_OUT),
  .OVERRANGE(OVERRANGE), .DATA_READY_N(DATA_READY_N));

// ### bench/adcal_conv_model.sv
// Purpose: conversion source beside the unit
// Assumes: a result every period+1 clocks once started
// Notes: data line inverts between strobes
`timescale 1ns/1ps
module adcal_conv_model (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire conv_start,
  input wire [23:0] sample,
  input wire [7:0] period,
  // result
  output reg filt_valid,
  output reg [23:0] filt_data
);
  reg run_reg; // conversions running
  reg [7:0] cnt_reg; // clocks to next result
  // restart on start pulse, free run after
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      cnt_reg <= 8'h00;
      filt_valid <= 1'b0;
      filt_data <= 24'h000000;
    end else begin
      filt_valid <= 1'b0;
      filt_data <= ~filt_data;
      if (conv_start) begin
        run_reg <= 1'b1;
        cnt_reg <= period;
      end else if (run_reg && cnt_reg == 8'h00) begin
        filt_valid <= 1'b1;
        filt_data <= sample;
        cnt_reg <= period;
      end else if (run_reg) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule // adcal_conv_model

// ### bench/adcal_unit_tb.sv
// Purpose: self-checking bench of adcal_unit
// Assumes: conversion model restarts on CONV_START
// Notes: expected words follow the observed samples
`timescale 1ns/1ps
module adcal_unit_tb;
  reg clk = 1'b0, rstn = 1'b0, wr = 1'b0, cv = 1'b0, lk = 1'b0, cs_n = 1'b0, chk_en = 1'b0;
  reg [7:0] adr = 8'h00, wd = 8'h00;
  reg [1:0] code = 2'h0, kind = 2'h0;
  reg [23:0] samp = 24'h000000, base = 24'h000000, msk = 24'hFFFFFF, ofs_m = 24'h000000, gain_m = 24'h400000;
  reg [31:0] r;
  integer seed = 32'h39B2BE80, fail_count = 0, num_checks = 0, cal_n = 17, j, n, k;
  longint sum, t, f, q[$];
  wire fv, cst, dv, ovr, data_ready_n_n, busy, disc;
  wire [7:0] rd;
  wire [23:0] fd, dout;
  always #50 clk = ~clk; // 10 MHz
  adcal_conv_model model (.clk(clk), .rst_n(rstn), .conv_start(cst), .sample(samp), .period(8'h3C),
    .filt_valid(fv), .filt_data(fd));
  adcal_unit dut (.REF_CLK(clk), .RSTN(rstn), .REG_WR(wr), .REG_ADDR(adr), .REG_WDATA(wd), .REG_RDATA(rd),
    .CMD_VALID(cv), .CMD_CODE(code), .REG_LOCKED(lk), .CS_N(cs_n), .FILT_VALID(fv), .FILT_DATA(fd),
    .CONV_START(cst), .INPUT_DISCONNECT(disc), .CAL_BUSY(busy), .DATA_VALID(dv), .DATA_OUT(dout),
    .OVERRANGE(ovr), .DATA_READY_N(data_ready_n_n));
  // clipped word with range flag on top
  function automatic [24:0] fin(input longint v);
    fin[23:0] = v > 64'sd8388607 ? 24'h7FFFFF : v < -64'sd8388608 ? 24'h800000 : v[23:0];
    fin[24] = v > 64'sh87AEDC || v < -64'sh87AEDC;
  endfunction
  task results;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string nm, input [24:0] seen, input [24:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait: 0 result, 1 idle, 2 start
  task waitfor(input integer lim, input integer sel);
    for (k = 1; k <= lim; k++) begin
      @(posedge clk);
      if (sel == 0 ? fv === 1'b1 : sel == 1 ? busy === 1'b0 : cst === 1'b1) break;
    end
    if (k > lim) begin
      fail_count++;
      results();
    end
  endtask
  task wr8(input [7:0] a, input [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task wr24(input [7:0] a, input [23:0] w);
    for (n = 0; n < 3; n++) wr8(a + n[7:0], w[8*n +: 8]);
  endtask
  task rd24(input [7:0] a, input [23:0] w, input string nm);
    for (n = 0; n < 3; n++) begin
      @(posedge clk);
      adr <= a + n[7:0];
      repeat (2) @(posedge clk);
      check(nm, {17'h0, rd}, {17'h0, w[8*n +: 8]});
    end
  endtask
  task cmd(input [1:0] c);
    if (c != 2'h0) waitfor(200, 0);
    cv <= 1'b1;
    code <= c;
    @(posedge clk);
    cv <= 1'b0;
    @(posedge clk);
  endtask
  // set both words just after a result
  task words(input [23:0] o, input [23:0] g);
    waitfor(200, 0);
    wr24(8'h07, o);
    wr24(8'h0A, g);
    ofs_m = o;
    gain_m = g;
  endtask
  // samples, averaging and result compare
  always @(posedge clk) begin
    if (fv) samp <= base + ($random(seed) & msk);
    if (cv && code != 2'h0 && !lk && !busy) begin
      cal_n = 0;
      sum = 0;
      kind = code;
    end
    if (dv && chk_en) begin
      if (q.size() == 0) check("extra result", 25'h1, 25'h0);
      else begin
        f = q.pop_front() >>> 22;
        check("result", {ovr, dout}, fin(f));
      end
    end
    if (fv && cal_n < 16) begin
      sum = sum + longint'($signed(fd));
      cal_n = cal_n + 1;
      if (cal_n == 16 && kind != 2'h3) ofs_m = sum >>> 4;
      if (cal_n == 16 && kind == 2'h3) begin
        t = (sum >>> 4) - longint'($signed(ofs_m));
        if (t > 0) t = (64'sh7FFFFF * 64'sh400000) / t;
        gain_m = (t <= 0 || t > 64'shFFFFFF) ? 24'hFFFFFF : t[23:0];
      end
    end else if (fv && chk_en) q.push_back((longint'($signed(fd)) - longint'($signed(ofs_m))) * longint'(gain_m));
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd24(8'h07, 24'h000000, "offset reset");
    rd24(8'h0A, 24'h400000, "gain reset");
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(2'h0);
    waitfor(600, 2);
    check("restart", k[24:0], 25'd512);
    chk_en <= 1'b1;
    for (j = 0; j < 4; j++) begin
      r = $random(seed);
      words(j == 0 ? 24'h000001 : j == 1 ? 24'h000000 : j == 2 ? 24'hFFFFFF : r[23:0],
        j == 0 ? 24'h400000 : j == 1 ? 24'h433333 : j == 2 ? 24'h3CCCCC : 24'h3C0000 + r[19:0]);
      rd24(8'h07, ofs_m, "offset word");
      rd24(8'h0A, gain_m, "gain word");
      repeat (200) @(posedge clk);
    end
    wr8(8'h0D, 8'h5A);
    rd24(8'h0D, 24'h000000, "unmapped");
    words(24'h000000, 24'h400000);
    lk <= 1'b1;
    cmd(2'h1);
    check("locked", {24'h0, busy}, 25'h0);
    lk <= 1'b0;
    base = 24'h000100;
    msk = 24'h0000FF;
    cmd(2'h2);
    waitfor(3000, 1);
    rd24(8'h07, ofs_m, "system offset");
    cmd(2'h1);
    waitfor(3000, 1);
    rd24(8'h07, ofs_m, "self offset");
    base = 24'h700000;
    cmd(2'h3);
    waitfor(3000, 1);
    rd24(8'h0A, gain_m, "full scale gain");
    cmd(2'h2);
    repeat (150) @(posedge clk);
    cs_n <= 1'b1;
    cal_n = 17;
    repeat (6) @(posedge clk);
    check("abort busy", {24'h0, busy}, 25'h0);
    rd24(8'h07, ofs_m, "abort offset");
    cs_n <= 1'b0;
    repeat (200) @(posedge clk);
    results();
  end
endmodule // adcal_unit_tb
